// ===== rtl/adc_serial_conversion_port.sv
// Converter control, result FIFO and serial link of the conversion port
`timescale 1ns/1ps
// Function
// - Rising convert strobe starts a conversion when idle; host drives that edge.
// - Strobe held high while converting drives a busy indication on result out.
// - Serial input fills a 14-bit configuration register, whole word per update.
// - Configuration writes are taken during and after a conversion.
// - Result and configuration bits move MSB first, one bit per serial clock.
// - Result leaves on the serial output, bits changing on serial clock.
// - Unipolar range gives straight binary results.
// - Bipolar range gives two's complement results.
// - Internal clock times the conversion; serial clock not needed.
// - First bit after strobe falls is bit 15.

module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count_q != FULL_COUNT);
	assign o_out_valid = (count_q != '0);
	assign o_out_data  = mem_q[rd_ptr_q];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_fifo_no_overrun: assert property (@(posedge i_clk) disable iff (i_reset)
		(count_q == FULL_COUNT && !pop) |=> (count_q == FULL_COUNT && $stable(wr_ptr_q)))
		else $error("fifo accepts data while full");
endmodule

module adc_serial_conversion_port #(
	parameter int CONV_CYCLES = adc_port_pkg::CONV_CYCLES,
	parameter int FIFO_DEPTH  = adc_port_pkg::FIFO_DEPTH
) (
	input  wire logic                              i_clk,
	input  wire logic                              i_reset,
	input  wire logic                              i_sck,
	input  wire logic                              i_convert_strobe,
	input  wire logic                              i_serial_config_in,
	input  wire adc_port_pkg::sar_sample_t         i_sar_sample,
	output logic                                   o_serial_result_out,
	output logic                                   o_serial_result_oe,
	output adc_port_pkg::cfg_word_t                o_config,
	output logic                                   o_conv_active
);
	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
	localparam int CONV_SPAN = CONV_CYCLES;

	// System clock domain
	adc_port_pkg::conv_state_t             state_q;
	logic [CW-1:0]                         conv_cnt_q;
	logic [adc_port_pkg::RESULT_W-1:0]     code_q;
	logic                                  cnv_s1_q;
	logic                                  cnv_s2_q;
	logic                                  cnv_s3_q;
	logic                                  busy_mode_q;
	logic                                  done_q;
	logic [adc_port_pkg::RESULT_W-1:0]     out_word_q;
	logic                                  fresh_q;
	logic [2:0]                            rd_sync_q;
	logic [2:0]                            cfg_sync_q;
	adc_port_pkg::cfg_word_t               config_q;
	logic                                  cnv_rise;
	logic                                  rd_done;
	logic                                  cfg_new;
	logic                                  fifo_in_ready;
	logic                                  fifo_out_valid;
	logic [adc_port_pkg::RESULT_W-1:0]     fifo_out_data;
	logic                                  load_word;
	// Serial clock domain
	logic [3:0]                            rd_cnt_q;
	logic                                  rd_tgl_q;
	logic [3:0]                            cfg_cnt_q;
	logic [adc_port_pkg::CFG_W-2:0]        cfg_shift_q;
	adc_port_pkg::cfg_word_t               cfg_word_q;
	logic                                  cfg_tgl_q;
	logic                                  frame_clear;

	assign cnv_rise  = cnv_s2_q && !cnv_s3_q;
	assign rd_done   = rd_sync_q[2] ^ rd_sync_q[1];
	assign cfg_new   = cfg_sync_q[2] ^ cfg_sync_q[1];
	assign load_word = fifo_out_valid && !fresh_q;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnv_s1_q <= 1'b0;
			cnv_s2_q <= 1'b0;
			cnv_s3_q <= 1'b0;
		end else begin
			cnv_s1_q <= i_convert_strobe;
			cnv_s2_q <= cnv_s1_q;
			cnv_s3_q <= cnv_s2_q;
		end
	end

	// Conversion sequencer on the internal clock
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_q    <= adc_port_pkg::CONV_IDLE;
			conv_cnt_q <= '0;
			code_q     <= adc_port_pkg::WORD_RESET;
		end else begin
			case (state_q)
				adc_port_pkg::CONV_IDLE: begin
					if (cnv_rise) begin
						state_q    <= adc_port_pkg::CONV_RUN;
						conv_cnt_q <= '0;
					end
				end
				adc_port_pkg::CONV_RUN: begin
					conv_cnt_q <= conv_cnt_q + 1'b1;
					if (conv_cnt_q == CONV_LAST) begin
						state_q <= adc_port_pkg::CONV_STORE;
						// Offset-binary core code; bipolar flips the sign bit
						code_q  <= i_sar_sample.code ^ {i_sar_sample.bipolar,
							15'h0000};
					end
				end
				adc_port_pkg::CONV_STORE: begin
					if (fifo_in_ready) begin
						state_q <= adc_port_pkg::CONV_IDLE;
					end
				end
				default: begin
					state_q <= adc_port_pkg::CONV_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_conv_active <= 1'b0;
		end else begin
			o_conv_active <= (state_q == adc_port_pkg::CONV_RUN);
		end
	end

	// Busy indication while the strobe stays high
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			busy_mode_q <= 1'b0;
			done_q      <= 1'b1;
		end else begin
			if (state_q == adc_port_pkg::CONV_IDLE && cnv_rise) begin
				busy_mode_q <= 1'b1;
				done_q      <= 1'b0;
			end else begin
				if (!cnv_s2_q) begin
					busy_mode_q <= 1'b0;
				end
				if (state_q == adc_port_pkg::CONV_STORE) begin
					done_q <= 1'b1;
				end
			end
		end
	end

	result_fifo #(
		.WIDTH (adc_port_pkg::RESULT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_reset     (i_reset),
		.i_in_valid  (state_q == adc_port_pkg::CONV_STORE),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (code_q),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (!fresh_q),
		.o_out_data  (fifo_out_data)
	);

	// Word for the link stays still until a whole frame has read it
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			out_word_q <= adc_port_pkg::WORD_RESET;
			fresh_q    <= 1'b0;
		end else if (load_word) begin
			out_word_q <= fifo_out_data;
			fresh_q    <= 1'b1;
		end else if (rd_done) begin
			fresh_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_sync_q  <= 3'h0;
			cfg_sync_q <= 3'h0;
		end else begin
			rd_sync_q  <= {rd_sync_q[1:0], rd_tgl_q};
			cfg_sync_q <= {cfg_sync_q[1:0], cfg_tgl_q};
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			config_q <= adc_port_pkg::CFG_RESET;
		end else if (cfg_new) begin
			config_q <= cfg_word_q;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_config <= adc_port_pkg::CFG_RESET;
		end else begin
			o_config <= config_q;
		end
	end

	// Link side: strobe high ends any frame
	assign frame_clear = i_reset || i_convert_strobe;

	always_ff @(negedge i_sck or posedge frame_clear) begin
		if (frame_clear) begin
			rd_cnt_q <= 4'h0;
		end else begin
			rd_cnt_q <= rd_cnt_q + 4'h1;
		end
	end

	always_ff @(negedge i_sck or posedge i_reset) begin
		if (i_reset) begin
			rd_tgl_q <= 1'b0;
		end else if (!i_convert_strobe && rd_cnt_q == adc_port_pkg::LAST_READ) begin
			rd_tgl_q <= !rd_tgl_q;
		end
	end

	always_ff @(posedge i_sck or posedge frame_clear) begin
		if (frame_clear) begin
			cfg_cnt_q <= 4'h0;
		end else if (cfg_cnt_q != adc_port_pkg::LAST_CFG + 4'h1) begin
			cfg_cnt_q <= cfg_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge i_sck or posedge i_reset) begin
		if (i_reset) begin
			cfg_shift_q <= '0;
			cfg_word_q  <= adc_port_pkg::CFG_RESET;
			cfg_tgl_q   <= 1'b0;
		end else if (!i_convert_strobe) begin
			cfg_shift_q <= {cfg_shift_q[adc_port_pkg::CFG_W-3:0], i_serial_config_in};
			if (cfg_cnt_q == adc_port_pkg::LAST_CFG) begin
				cfg_word_q <= {cfg_shift_q, i_serial_config_in};
				cfg_tgl_q  <= !cfg_tgl_q;
			end
		end
	end

	// Pad driver: frame data while strobe low, busy flag while high
	assign o_serial_result_out = i_convert_strobe ? done_q
		: out_word_q[4'hF - rd_cnt_q];
	assign o_serial_result_oe  = !i_convert_strobe || busy_mode_q;

	a_start_on_edge: assert property (@(posedge i_clk) disable iff (i_reset)
		(cnv_rise && state_q == adc_port_pkg::CONV_IDLE) |=> state_q == adc_port_pkg::CONV_RUN)
		else $error("strobe edge did not start a conversion");
	a_conv_length: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(state_q == adc_port_pkg::CONV_RUN) |-> ##CONV_SPAN
		state_q == adc_port_pkg::CONV_STORE)
		else $error("conversion time wrong");
	a_busy_shown: assert property (@(posedge i_clk) disable iff (i_reset)
		($rose(state_q == adc_port_pkg::CONV_RUN) && cnv_s2_q) |->
		(busy_mode_q && !done_q))
		else $error("busy indication missing during conversion");
	a_unipolar_code: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_q == adc_port_pkg::CONV_RUN && conv_cnt_q == CONV_LAST && !i_sar_sample.bipolar)
		|=> code_q == $past(i_sar_sample.code))
		else $error("unipolar code not straight binary");
	a_bipolar_code: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_q == adc_port_pkg::CONV_RUN && conv_cnt_q == CONV_LAST && i_sar_sample.bipolar)
		|=> code_q == {!$past(i_sar_sample.code[15]), $past(i_sar_sample.code[14:0])})
		else $error("bipolar code not twos complement");
	a_config_taken: assert property (@(posedge i_clk) disable iff (i_reset)
		cfg_new |=> ##1 o_config == $past(cfg_word_q, 2))
		else $error("configuration word not applied");
	a_first_bit: assert property (@(posedge i_clk) disable iff (i_reset)
		(!i_convert_strobe && rd_cnt_q == 4'h0) |-> o_serial_result_out == out_word_q[15])
		else $error("first result bit is not bit 15");
	a_msb_order: assert property (@(negedge i_sck) disable iff (i_reset)
		(!i_convert_strobe && rd_cnt_q != adc_port_pkg::LAST_READ) |=>
		(i_convert_strobe || o_serial_result_out == out_word_q[4'hE - $past(rd_cnt_q)]))
		else $error("result bits not sent msb first");
	a_word_still: assert property (@(posedge i_clk) disable iff (i_reset)
		(fresh_q && !rd_done) |=> $stable(out_word_q))
		else $error("result word changed during a frame");
endmodule

// ===== inc/adc_port_pkg.sv
// Shared constants and types of the converter serial port
package adc_port_pkg;
	localparam int RESULT_W      = 16;
	localparam int CFG_W         = 14;
	localparam int FIFO_DEPTH    = 8;
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONV_TIME_NS  = 2200;
	// Longest time, rounded down
	localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam logic [CFG_W-1:0]    CFG_RESET  = 14'h0000;
	localparam logic [RESULT_W-1:0] WORD_RESET = 16'h0000;
	localparam logic [3:0]          LAST_READ  = 4'hF;
	localparam logic [3:0]          LAST_CFG   = 4'hD;

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_RUN,
		CONV_STORE
	} conv_state_t;

	// Raw code from the successive-approximation core
	typedef struct packed {
		logic                bipolar;
		logic [RESULT_W-1:0] code;
	} sar_sample_t;

	typedef struct packed {
		logic [CFG_W-1:0] bits;
	} cfg_word_t;
endpackage

// ===== testbench/host_link_model.sv
// Host side of the serial link: strobe, serial clock, config data
`timescale 1ns/1ps
module host_link_model (
	output logic      o_strobe,
	output logic      o_sck,
	output logic      o_din,
	input  wire logic i_sdo
);
	initial begin
		o_strobe = 1'b0;
		o_sck    = 1'b0;
		o_din    = 1'b0;
	end

	task automatic set_strobe(input logic v);
		o_strobe <= v;
	endtask

	task automatic pulse(input int hold_ns);
		o_strobe <= 1'b1;
		#(hold_ns);
		o_strobe <= 1'b0;
	endtask

	// Serial clock runs only inside the frame; data line never holds its last value
	task automatic frame(input logic [13:0] cfg, output logic [15:0] rd);
		#24;
		for (int i = 0; i < 16; i++) begin
			o_din = (i < 14) ? cfg[13 - i] : ~o_din;
			#24;
			o_sck = 1'b1;
			rd    = {rd[14:0], i_sdo};
			#24;
			o_sck = 1'b0;
		end
		o_din = ~o_din;
	endtask
endmodule

// ===== testbench/tb.sv
// Self-checking testbench of the converter serial port
`timescale 1ns/1ps
module tb;
	localparam int CONV = 30;
	logic                      i_clk;
	logic                      i_reset;
	logic                      sck;
	logic                      strobe;
	logic                      din;
	logic                      serial_result_out;
	logic                      sdo_oe;
	logic                      conv_active;
	adc_port_pkg::sar_sample_t sample;
	adc_port_pkg::cfg_word_t   cfg;
	logic [15:0]               exp_q[$];
	logic [15:0]               rd;
	logic [13:0]               cfg_w;
	logic [15:0]               corner[4] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};
	int                        error_cnt = 0;
	int                        comparisons = 0;
	int                        cycles = 0;

	adc_serial_conversion_port #(.CONV_CYCLES(CONV)) u_adc_serial_conversion_port (
		.i_clk              (i_clk),
		.i_reset            (i_reset),
		.i_sck              (sck),
		.i_convert_strobe   (strobe),
		.i_serial_config_in (din),
		.i_sar_sample       (sample),
		.o_serial_result_out(serial_result_out),
		.o_serial_result_oe (sdo_oe),
		.o_config           (cfg),
		.o_conv_active      (conv_active)
	);

	host_link_model u_host_link_model (
		.o_strobe(strobe),
		.o_sck   (sck),
		.o_din   (din),
		.i_sdo   (serial_result_out)
	);

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	function automatic logic [15:0] expect_word(input logic bip, input logic [15:0] code);
		return bip ? {~code[15], code[14:0]} : code;
	endfunction

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Presents a sample and queues the word the host should read for it
	task automatic load(input logic [15:0] code, input logic bip);
		@(posedge i_clk);
		sample <= '{bip, code};
		@(posedge i_clk);
		exp_q.push_back(expect_word(bip, code));
	endtask

	task automatic read_frame();
		logic [15:0] e;
		cfg_w = 14'($urandom);
		u_host_link_model.frame(cfg_w, rd);
		e = exp_q.pop_front();
		chk16(rd, e, "result word");
	endtask

	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			conclude();
		end
	end

	initial begin
		i_reset = 1'b1;
		sample  = '0;
		void'($urandom(32'h3202));
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
		repeat (5) @(posedge i_clk);
		// Nine words fill the output register and the FIFO
		for (int i = 0; i < 9; i++) begin
			load(i < 4 ? corner[i] : 16'($urandom), 1'($urandom));
			u_host_link_model.pulse(120);
			repeat (45) @(posedge i_clk);
		end
		$display("test fill done");
		// Two reads per conversion; second strobe lands in the run and is ignored
		for (int i = 0; i < 8; i++) begin
			load(16'($urandom), 1'($urandom));
			u_host_link_model.pulse(120);
			read_frame();
			u_host_link_model.pulse(120);
			repeat (2) @(posedge i_clk);
			@(negedge i_clk);
			chk16({2'h0, cfg.bits}, {2'h0, cfg_w}, "config during run");
			read_frame();
			repeat (45) @(posedge i_clk);
			chk16({2'h0, cfg.bits}, {2'h0, cfg_w}, "config after run");
		end
		$display("test drain done");
		load(16'h1234, 1'b1);
		u_host_link_model.set_strobe(1'b1);
		repeat (10) @(posedge i_clk);
		@(negedge i_clk);
		chk1(serial_result_out, 1'b0, "busy level");
		chk1(sdo_oe, 1'b1, "busy drive");
		chk1(conv_active, 1'b1, "running without serial clock");
		repeat (40) @(posedge i_clk);
		@(negedge i_clk);
		chk1(serial_result_out, 1'b1, "done level");
		chk1(conv_active, 1'b0, "conversion over");
		u_host_link_model.set_strobe(1'b0);
		read_frame();
		$display("test busy done");
		conclude();
	end
endmodule
